//--- rtl/dnpa_params.svh
// Purpose: Constants for the data memory page access sequencer.
// Assumes: Included by bare name from the design files.
// Notes: Times are in microseconds, the clock period in nanoseconds.
`ifndef DNPA_PARAMS_SVH
`define DNPA_PARAMS_SVH

`define DNPA_OFS_ADDR_LO 3'h0
`define DNPA_OFS_ADDR_HI 3'h1
`define DNPA_OFS_DATA 3'h2
`define DNPA_OFS_CTRL 3'h3
`define DNPA_OFS_IRQ 3'h4

`define DNPA_CTRL_RST 8'h00
`define DNPA_BIT_TSEL 7
`define DNPA_BIT_WEN 6
`define DNPA_BIT_WGO 5
`define DNPA_BIT_MODE 4
`define DNPA_BIT_PEN 3
`define DNPA_BIT_PGO 2
`define DNPA_BIT_FEN 1
`define DNPA_BIT_FGO 0

`define DNPA_BIT_NVM_ON 0
`define DNPA_BIT_NVM_FLAG 1
`define DNPA_BIT_MF_ON 2
`define DNPA_BIT_MF_FLAG 3

`define DNPA_CLK_NS 10
`define DNPA_T_ERASE0_US 3200
`define DNPA_T_PROG0_US 2200
`define DNPA_T_ERASE1_US 3700
`define DNPA_T_PROG1_US 3000
`define DNPA_READ_CYC 2

`endif

//--- rtl/dnpa_pkg.sv
// Purpose: Types for the data memory page access sequencer.
// Assumes: Nothing beyond the language.
// Notes: States follow a Gray path from idle.
package dnpa_pkg;
    typedef enum logic [1:0] {
        DNPA_IDLE = 2'b00,
        DNPA_READ = 2'b01,
        DNPA_PROG = 2'b11,
        DNPA_ERASE = 2'b10
    } dnpa_state_t;
endpackage : dnpa_pkg

//--- rtl/dnpa_data_nvm_page_access.sv
// Purpose: Sequencer for a 512-byte data memory with byte and page modes.
// Assumes: One clock, synchronous active-low reset, plain register port.
// Notes: Erase and program durations are parameters so tests can shorten.
`timescale 1ns/1ps
`include "dnpa_params.svh"
`default_nettype none

module dnpa_data_nvm_page_access
    import dnpa_pkg::*;
#(
    parameter int ERASE0_CYC = `DNPA_T_ERASE0_US * 1000 / `DNPA_CLK_NS,
    parameter int PROG0_CYC = `DNPA_T_PROG0_US * 1000 / `DNPA_CLK_NS,
    parameter int ERASE1_CYC = `DNPA_T_ERASE1_US * 1000 / `DNPA_CLK_NS,
    parameter int PROG1_CYC = `DNPA_T_PROG1_US * 1000 / `DNPA_CLK_NS,
    parameter int TW = 20
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input wire logic [2:0] busAddr,
    input wire logic [7:0] busWdata,
    input wire logic busWe,
    input wire logic busRe,
    output logic [7:0] busRdata,
    // System interrupt context.
    input wire logic globalIrqOn,
    input wire logic stackFull,
    input wire logic irqService,
    // Status.
    output logic irqReq,
    output logic busy
);
    localparam int READ_CYC = `DNPA_READ_CYC;

    function automatic logic [3:0] dnpa_adv(input logic [3:0] n);
        return (n == 4'hF) ? n : n + 4'h1;
    endfunction : dnpa_adv

    dnpa_state_t state;
    dnpa_state_t next_state;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] addrLo;
    logic addrHi;
    logic [7:0] dataReg;
    logic [3:0] irqBits;
    logic [7:0] mem [512];
    logic [7:0] pageBuf [16];
    logic [15:0] tags;
    logic endHeld;
    logic [TW-1:0] cnt;

    wire idle = (state == DNPA_IDLE);
    wire pageMode = ctrl[`DNPA_BIT_MODE];
    wire timeSel = ctrl[`DNPA_BIT_TSEL];
    wire [8:0] fullAddr = {addrHi, addrLo};
    wire [4:0] pageSel = fullAddr[8:4];
    wire [3:0] nib = addrLo[3:0];
    wire wrCtrl = busWe && (busAddr == `DNPA_OFS_CTRL);
    // Data port writes are refused while a cycle runs, so buffer loads cannot step the
    // low address or fill the page buffer under a cycle in flight.
    wire wrData = busWe && (busAddr == `DNPA_OFS_DATA) && idle;
    wire wrLo = busWe && (busAddr == `DNPA_OFS_ADDR_LO);
    wire wrHi = busWe && (busAddr == `DNPA_OFS_ADDR_HI);
    wire wrIrq = busWe && (busAddr == `DNPA_OFS_IRQ);
    wire startErase = idle && wrCtrl && busWdata[`DNPA_BIT_WGO]
        && ctrl[`DNPA_BIT_WEN];
    wire startProg = idle && wrCtrl && !startErase
        && busWdata[`DNPA_BIT_PGO] && ctrl[`DNPA_BIT_PEN];
    wire startRead = idle && wrCtrl && !startErase && !startProg
        && busWdata[`DNPA_BIT_FGO] && ctrl[`DNPA_BIT_FEN];
    wire cntZero = (cnt == '0);
    wire readEnd = (state == DNPA_READ) && cntZero;
    wire progEnd = (state == DNPA_PROG) && cntZero;
    wire eraseEnd = (state == DNPA_ERASE) && cntZero;
    wire opDone = progEnd || eraseEnd;
    wire wipeFall = ctrl[`DNPA_BIT_WEN] && !next_ctrl[`DNPA_BIT_WEN];
    wire progFall = ctrl[`DNPA_BIT_PEN] && !next_ctrl[`DNPA_BIT_PEN];
    // Only a falling erase or program enable drops the buffer; a rising one keeps it.
    wire bufClear = wipeFall || progFall;
    wire bufLoad = wrData && pageMode && !endHeld;
    wire [TW-1:0] eraseLen = timeSel ? TW'(ERASE1_CYC - 1)
        : TW'(ERASE0_CYC - 1);
    wire [TW-1:0] progLen = timeSel ? TW'(PROG1_CYC - 1)
        : TW'(PROG0_CYC - 1);
    wire [7:0] rdSel =
        (busAddr == `DNPA_OFS_ADDR_LO) ? addrLo :
        (busAddr == `DNPA_OFS_ADDR_HI) ? {7'h00, addrHi} :
        (busAddr == `DNPA_OFS_DATA) ? dataReg :
        (busAddr == `DNPA_OFS_CTRL) ? ctrl :
        (busAddr == `DNPA_OFS_IRQ) ? {4'h0, irqBits} : 8'h00;

    // Control register: kicks only stick when accepted, hardware clears.
    always_comb begin
        next_ctrl = ctrl;
        if (wrCtrl) begin
            if (idle) begin
                next_ctrl = busWdata;
                next_ctrl[`DNPA_BIT_WGO] = startErase;
                next_ctrl[`DNPA_BIT_PGO] = startProg;
                next_ctrl[`DNPA_BIT_FGO] = startRead;
            end else begin
                next_ctrl[`DNPA_BIT_TSEL] = busWdata[`DNPA_BIT_TSEL];
                next_ctrl[`DNPA_BIT_MODE] = busWdata[`DNPA_BIT_MODE];
            end
        end
        if (readEnd) begin
            next_ctrl[`DNPA_BIT_FGO] = 1'b0;
        end
        if (progEnd) begin
            next_ctrl[`DNPA_BIT_PGO] = 1'b0;
            next_ctrl[`DNPA_BIT_PEN] = 1'b0;
        end
        if (eraseEnd) begin
            next_ctrl[`DNPA_BIT_WGO] = 1'b0;
            next_ctrl[`DNPA_BIT_WEN] = 1'b0;
        end
    end

    // Start priority is erase, then program, then read.
    always_comb begin
        next_state = state;
        case (state)
            DNPA_IDLE: begin
                if (startErase) begin
                    next_state = DNPA_ERASE;
                end else if (startProg) begin
                    next_state = DNPA_PROG;
                end else if (startRead) begin
                    next_state = DNPA_READ;
                end
            end
            default: begin
                if (cntZero) begin
                    next_state = DNPA_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= DNPA_IDLE;
            ctrl <= `DNPA_CTRL_RST;
        end else begin
            state <= next_state;
            ctrl <= next_ctrl;
        end
    end

    // Cycle timer stands in for the memory's own timing source.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt <= '0;
        end else if (startErase) begin
            cnt <= eraseLen;
        end else if (startProg) begin
            cnt <= progLen;
        end else if (startRead) begin
            cnt <= TW'(READ_CYC - 1);
        end else if (!cntZero) begin
            cnt <= cnt - TW'(1);
        end
    end

    // Address: bus loads win; page reads and buffer loads advance the nibble.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            addrLo <= 8'h00;
            addrHi <= 1'b0;
            endHeld <= 1'b0;
        end else if (wrLo) begin
            addrLo <= busWdata;
            endHeld <= 1'b0;
        end else if (wrHi) begin
            addrHi <= busWdata[0];
        end else if ((readEnd && pageMode) || bufLoad) begin
            addrLo[3:0] <= dnpa_adv(nib);
            // Once a write lands at the page end, later data stays out of
            // the buffer until the low address is loaded again.
            endHeld <= endHeld || (bufLoad && (nib == 4'hF));
        end
    end

    // The data register keeps the last byte read or written until the next.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            dataReg <= 8'h00;
        end else if (readEnd) begin
            dataReg <= mem[fullAddr];
        end else if (wrData) begin
            dataReg <= busWdata;
        end
    end

    // Page buffer and its location tags.
    always_ff @(posedge clk) begin
        if (!nrst || bufClear) begin
            tags <= 16'h0000;
            for (int i = 0; i < 16; i++) begin
                pageBuf[i] <= 8'h00;
            end
        end else if (bufLoad) begin
            tags[nib] <= 1'b1;
            pageBuf[nib] <= busWdata;
        end
    end

    // Memory array updates at the end of erase and program cycles.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            for (int i = 0; i < 512; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (eraseEnd) begin
            if (pageMode) begin
                for (int i = 0; i < 16; i++) begin
                    if (tags[i]) begin
                        mem[{pageSel, 4'(i)}] <= 8'h00;
                    end
                end
            end else begin
                mem[fullAddr] <= 8'h00;
            end
        end else if (progEnd) begin
            if (pageMode) begin
                for (int i = 0; i < 16; i++) begin
                    if (tags[i]) begin
                        mem[{pageSel, 4'(i)}] <= pageBuf[i];
                    end
                end
            end else begin
                mem[fullAddr] <= dataReg;
            end
        end
    end

    // Interrupt bits: hardware set wins over a software clear.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            irqBits <= 4'h0;
        end else begin
            if (wrIrq) begin
                irqBits <= busWdata[3:0];
            end
            if (irqService && !wrIrq) begin
                irqBits[`DNPA_BIT_MF_FLAG] <= 1'b0;
            end
            if (opDone) begin
                irqBits[`DNPA_BIT_NVM_FLAG] <= 1'b1;
                irqBits[`DNPA_BIT_MF_FLAG] <= 1'b1;
            end
        end
    end

    // Read data stand for one cycle after the strobe and are zero otherwise.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            busRdata <= 8'h00;
        end else if (busRe) begin
            busRdata <= rdSel;
        end else begin
            busRdata <= 8'h00;
        end
    end

    assign irqReq = irqBits[`DNPA_BIT_MF_FLAG] && irqBits[`DNPA_BIT_NVM_ON]
        && irqBits[`DNPA_BIT_MF_ON] && globalIrqOn && !stackFull;
    assign busy = !idle;

    read_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        idle && wrCtrl && busWdata[0] && !ctrl[1] && !busWdata[5]
        && !busWdata[2] |=> !ctrl[0] && state == DNPA_IDLE)
        else $error("read started without read enable");
    prog_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        wrCtrl && busWdata[2] && !ctrl[3] |=> state != DNPA_PROG)
        else $error("program started without program enable");
    read_len_a: assert property (@(posedge clk) disable iff (!nrst)
        startRead |=> ctrl[0] ##1 ctrl[0] ##1 !ctrl[0] && state == DNPA_IDLE)
        else $error("read cycle length wrong");
    nib_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        readEnd && pageMode && nib == 4'hF && !wrLo |=> nib == 4'hF)
        else $error("page address wrapped");
    page_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        (readEnd || bufLoad) && !wrLo && !wrHi
        |=> pageSel == $past(pageSel))
        else $error("page selector changed");
    prog_end_a: assert property (@(posedge clk) disable iff (!nrst)
        progEnd |=> !ctrl[2] && !ctrl[3] && irqBits[1] && irqBits[3])
        else $error("program end not reported");
    erase_end_a: assert property (@(posedge clk) disable iff (!nrst)
        eraseEnd |=> !ctrl[5] && !ctrl[6] && irqBits[1])
        else $error("erase end not reported");
    buf_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        bufClear |=> tags == 16'h0000)
        else $error("page buffer not cleared");
    irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        irqReq |-> globalIrqOn && !stackFull && irqBits[0] && irqBits[2])
        else $error("interrupt request without enables");
    busy_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        !idle && !cntZero |=> $stable(state))
        else $error("cycle disturbed while running");

    // Data path and flag checks.
    data_gate_a: assert property (@(posedge clk) disable iff (!nrst)
        busWe && busAddr == `DNPA_OFS_DATA && !idle && !readEnd && !opDone
        |=> $stable(dataReg) && $stable(tags))
        else $error("data port write taken while busy");
    buf_full_a: assert property (@(posedge clk) disable iff (!nrst)
        wrData && endHeld && !bufClear |=> $stable(tags) && nib == 4'hF)
        else $error("write past page end reached the buffer");
    tag_step_a: assert property (@(posedge clk) disable iff (!nrst)
        bufLoad && nib != 4'hF |=> nib == $past(nib) + 4'h1)
        else $error("low address did not advance on a data write");
    read_data_a: assert property (@(posedge clk) disable iff (!nrst)
        readEnd |=> dataReg == $past(mem[fullAddr]))
        else $error("read byte not presented");
    prog_byte_a: assert property (@(posedge clk) disable iff (!nrst)
        progEnd && !pageMode && !wrLo && !wrHi
        |=> mem[fullAddr] == $past(dataReg))
        else $error("byte program did not land");
    wipe_zero_a: assert property (@(posedge clk) disable iff (!nrst)
        eraseEnd && pageMode && tags[0] && !wrLo && !wrHi
        |=> mem[{pageSel, 4'h0}] == 8'h00)
        else $error("tagged location not erased");
    svc_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        irqService && !wrIrq && !opDone
        |=> !irqBits[3] && irqBits[1] == $past(irqBits[1]))
        else $error("service cleared more than the shared flag");
    ctrl_reset_a: assert property (@(posedge clk) !nrst
        |=> ctrl == `DNPA_CTRL_RST)
        else $error("control not cleared by reset");

    page_read_c: cover property (@(posedge clk) disable iff (!nrst)
        readEnd && pageMode ##[1:20] readEnd);
    erase_done_c: cover property (@(posedge clk) disable iff (!nrst)
        eraseEnd && pageMode && tags != 16'h0000);
    prog_done_c: cover property (@(posedge clk) disable iff (!nrst)
        progEnd && irqReq == 1'b0 ##[1:10] irqReq);
    byte_read_c: cover property (@(posedge clk) disable iff (!nrst)
        readEnd && !pageMode);
    irq_serve_c: cover property (@(posedge clk) disable iff (!nrst)
        irqService && irqBits[3]);
endmodule : dnpa_data_nvm_page_access

`default_nettype wire

//--- verification/dnpa_data_nvm_page_access_tb_top.sv
// Purpose: Self-checking bench for the data memory page access sequencer.
// Assumes: Short cycle times; register port driven right after rising edges.
// Notes: Random data comes from a bench LFSR with a fixed start value.
`timescale 1ns/1ps
`include "dnpa_params.svh"
`default_nettype none

module dnpa_data_nvm_page_access_tb_top;
    import dnpa_pkg::*;

    localparam int E0 = 8;
    localparam int P0 = 6;
    localparam int E1 = 10;
    localparam int P1 = 12;
    localparam logic [2:0] LO = `DNPA_OFS_ADDR_LO;
    localparam logic [2:0] HI = `DNPA_OFS_ADDR_HI;
    localparam logic [2:0] DAT = `DNPA_OFS_DATA;
    localparam logic [2:0] CTL = `DNPA_OFS_CTRL;
    localparam logic [2:0] IRQ = `DNPA_OFS_IRQ;

    logic clk, nrst, busWe, busRe, globalIrqOn, stackFull, irqService;
    logic [2:0] busAddr;
    logic [7:0] busWdata, busRdata, rv;
    logic irqReq, busy;
    logic [31:0] rnd;
    logic [4:0] page;
    logic [7:0] expPage [16];
    logic [7:0] fillBuf [16];
    int error_cnt, n_checks, cycles, n;

    dnpa_data_nvm_page_access #(.ERASE0_CYC(E0), .PROG0_CYC(P0),
        .ERASE1_CYC(E1), .PROG1_CYC(P1)) dut_u (
        .clk(clk), .nrst(nrst), .busAddr(busAddr), .busWdata(busWdata),
        .busWe(busWe), .busRe(busRe), .busRdata(busRdata),
        .globalIrqOn(globalIrqOn), .stackFull(stackFull),
        .irqService(irqService), .irqReq(irqReq), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] endAddr(input logic [4:0] p);
        return {p[3:0], 4'hF};
    endfunction : endAddr

    task automatic nextRnd();
        rnd = lfsr(rnd);
    endtask : nextRnd

    task automatic end_of_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The write strobe stays up after its edge so writes can run back to
    // back; the next read or an idle wait lowers it.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        busAddr <= a;
        busWdata <= d;
        busWe <= 1'b1;
        busRe <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        busAddr <= a;
        busWe <= 1'b0;
        busRe <= 1'b1;
        @(posedge clk);
        busRe <= 1'b0;
        #1;
        d = busRdata;
    endtask : rd

    // Counts the cycles in which busy stands high, bounded against a hang.
    task automatic waitIdle(output int cnt);
        cnt = 0;
        busWe <= 1'b0;
        #1;
        while (busy === 1'b1 && cnt < 1000) begin
            @(posedge clk);
            #1;
            cnt++;
        end
        if (cnt >= 1000) begin
            error_cnt++;
            $display("[ERR] %0t cycle did not end", $time);
        end
    endtask : waitIdle

    task automatic setAddr();
        wr(HI, {7'h00, page[4]});
        wr(LO, {page[3:0], 4'h0});
    endtask : setAddr

    task automatic fill(input int cnt);
        setAddr();
        for (int i = 0; i < cnt; i++) begin
            nextRnd();
            wr(DAT, rnd[7:0]);
            if (i < 16) fillBuf[i] = rnd[7:0];
        end
    endtask : fill

    task automatic pageRead();
        setAddr();
        wr(CTL, 8'h12);
        for (int i = 0; i < 17; i++) begin
            wr(CTL, 8'h13);
            waitIdle(n);
            rd(DAT, rv);
            chk(rv, expPage[(i > 15) ? 15 : i]);
        end
        rd(LO, rv);
        chk(rv, endAddr(page));
        rd(HI, rv);
        chk(rv, {7'h00, page[4]});
        wr(CTL, 8'h10);
    endtask : pageRead

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[ERR] %0t run did not finish in time", $time);
            end_of_test();
        end
    end

    initial begin
        logic [7:0] bd;
        logic [3:0] nb;
        {nrst, busWe, busRe, globalIrqOn, stackFull, irqService} = 6'h00;
        busAddr = 3'h0;
        busWdata = 8'h00;
        rnd = 32'hFB85;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(CTL, rv);
        chk(rv, 8'h00);
        rd(IRQ, rv);
        chk(rv, 8'h00);
        chk({7'h00, busy}, 8'h00);
        wr(CTL, 8'h01);
        rd(CTL, rv);
        chk(rv, 8'h00);
        wr(CTL, 8'h04);
        rd(CTL, rv);
        chk(rv, 8'h00);
        chk({7'h00, busy}, 8'h00);
        nextRnd();
        page = rnd[4:0];
        nb = rnd[8:5];
        bd = rnd[16:9] | 8'h01;
        wr(HI, {7'h00, page[4]});
        wr(LO, {page[3:0], nb});
        wr(DAT, bd);
        wr(CTL, 8'h08);
        wr(CTL, 8'h0C);
        waitIdle(n);
        chk(8'(n), 8'(P0));
        rd(CTL, rv);
        chk(rv, 8'h00);
        rd(IRQ, rv);
        chk(rv, 8'h0A);
        wr(DAT, 8'h00);
        wr(CTL, 8'h02);
        wr(CTL, 8'h03);
        waitIdle(n);
        rd(CTL, rv);
        chk(rv, 8'h02);
        rd(DAT, rv);
        chk(rv, bd);
        wr(IRQ, 8'h0F);
        busWe <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            globalIrqOn <= i[0];
            stackFull <= i[1];
            @(posedge clk);
            #1;
            chk({7'h00, irqReq}, {7'h00, i[0] & ~i[1]});
        end
        irqService <= 1'b1;
        @(posedge clk);
        irqService <= 1'b0;
        globalIrqOn <= 1'b0;
        stackFull <= 1'b0;
        rd(IRQ, rv);
        chk(rv, 8'h07);
        chk({7'h00, irqReq}, 8'h00);
        wr(IRQ, 8'h00);
        wr(CTL, 8'h90);
        fill(16);
        rd(LO, rv);
        chk(rv, endAddr(page));
        wr(CTL, 8'hD0);
        wr(CTL, 8'hF0);
        waitIdle(n);
        chk(8'(n), 8'(E1));
        rd(CTL, rv);
        chk(rv, 8'h90);
        wr(CTL, 8'h10);
        for (int i = 0; i < 16; i++) expPage[i] = 8'h00;
        pageRead();
        fill(17);
        for (int i = 0; i < 16; i++) expPage[i] = fillBuf[i];
        wr(CTL, 8'h18);
        wr(CTL, 8'h1C);
        wr(CTL, 8'h13);
        rd(CTL, rv);
        chk(rv, 8'h1C);
        waitIdle(n);
        pageRead();
        fill(8);
        wr(CTL, 8'h50);
        wr(CTL, 8'h70);
        waitIdle(n);
        for (int i = 0; i < 8; i++) expPage[i] = 8'h00;
        pageRead();
        fill(10);
        wr(CTL, 8'h18);
        wr(CTL, 8'h10);
        wr(CTL, 8'h50);
        wr(CTL, 8'h70);
        waitIdle(n);
        pageRead();
        fill(2);
        wr(CTL, 8'h50);
        wr(CTL, 8'h10);
        wr(CTL, 8'h18);
        wr(CTL, 8'h1C);
        waitIdle(n);
        pageRead();
        end_of_test();
    end
endmodule : dnpa_data_nvm_page_access_tb_top

`default_nettype wire
